//--- src/pfc_pkg.sv
// Package of constants and types for the parallel flash bus controller.
// Operation
// - Non-read operations start only by bus writes.
// - On bad sequence, pulse reset low to recover.
// - Read and write pin levels as defined.
// - Write cycles carry data; polling returns data.
// - Byte mode: top data pin carries lowest address.
// - Host drives all address bits, plus byte bit.
package pfc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W       = 26;
  localparam int unsigned SECT_OFF_W   = 16;
  localparam int unsigned SECT_W       = ADDR_W - SECT_OFF_W;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned SECT_MAX_CNT = 1024;

  // ****************************************************************
  // Timing at 10 MHz
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned STROBE_NS      = 200;
  localparam int unsigned RESET_PULSE_NS = 500;
  localparam int unsigned STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_CYC   = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W       = 4;

  // ****************************************************************
  // Controller states
  // ****************************************************************
  typedef enum logic [4:0] {
    PFC_IDLE  = 5'b00001,
    PFC_READ  = 5'b00010,
    PFC_WRITE = 5'b00100,
    PFC_RESET = 5'b01000,
    PFC_DONE  = 5'b10000
  } pfc_state_t;

endpackage

//--- src/pfc_timer.sv
// Down counter that times strobe and reset pulses.
`timescale 1ns/1ps
`default_nettype none
module pfc_timer
  import pfc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] value,
  // Status
  output var  logic             expired
);

  logic [CNT_W-1:0] count;

  // Load wins over counting so a new phase always gets its full length.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
    end else if (load) begin
      count <= value;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  assign expired = (count == 4'h0) && !load;

endmodule
`default_nettype wire

//--- src/pfc_ctrl.sv
// Host-side controller driving an asynchronous parallel NOR flash.
`timescale 1ns/1ps
`default_nettype none
module pfc_ctrl
  import pfc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // User request port
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic                  req_reset,
  input  wire logic [SECT_W-1:0]     req_sector,
  input  wire logic [SECT_OFF_W-1:0] req_offset,
  input  wire logic                  req_byte_hi,
  input  wire logic [DATA_W-1:0]     req_wdata,
  input  wire logic                  byte_mode,
  input  wire logic                  protect_outer,
  output logic                       req_ready,
  output logic                       rsp_valid,
  output logic [DATA_W-1:0]          rsp_rdata,
  // Flash pins
  output logic                       flash_ce_n,
  output logic                       flash_oe_n,
  output logic                       flash_we_n,
  output logic                       flash_reset_n,
  output logic                       flash_byte_n,
  output logic                       protect_accel_pin,
  output logic [ADDR_W-1:0]          flash_addr,
  input  wire logic [DATA_W-1:0]     flash_dq_i,
  output logic [DATA_W-1:0]          flash_dq_o,
  output logic [DATA_W-1:0]          flash_dq_oe_n
);

  pfc_state_t       state;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_expired;

  // Sector numbering wraps to the device size by plain address width.
  function automatic logic [ADDR_W-1:0] word_addr(input logic [SECT_W-1:0] s,
                                                  input logic [SECT_OFF_W-1:0] o);
    word_addr = {s, o};
  endfunction

  // ****************************************************************
  // Pulse timer
  // ****************************************************************
  pfc_timer u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .load    (tmr_load),
    .value   (tmr_value),
    .expired (tmr_expired)
  );

  // Timer is loaded as each active phase starts.
  always_comb begin
    tmr_load  = (state == PFC_IDLE) && req_valid;
    tmr_value = req_reset ? CNT_W'(RESET_CYC) : CNT_W'(STROBE_CYC);
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Reset requests outrank access requests so a stuck device recovers first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PFC_IDLE;
    end else begin
      unique case (state)
        PFC_IDLE: begin
          if (req_valid) begin
            state <= req_reset ? PFC_RESET : (req_write ? PFC_WRITE : PFC_READ);
          end
        end
        PFC_READ, PFC_WRITE, PFC_RESET: begin
          if (tmr_expired) begin
            state <= PFC_DONE;
          end
        end
        PFC_DONE: begin
          state <= PFC_IDLE;
        end
        default: begin
          state <= PFC_IDLE;
        end
      endcase
    end
  end

  // Ready only when idle; next request is taken the cycle after DONE.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == PFC_DONE) || ((state == PFC_IDLE) && !req_valid);
    end
  end

  // ****************************************************************
  // Control pins
  // ****************************************************************
  // Between accesses CE, OE and WE stay high: standby, so nothing is latched.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end else if ((state == PFC_IDLE) && req_valid) begin
      flash_ce_n    <= req_reset;
      flash_oe_n    <= req_reset | req_write;
      flash_we_n    <= req_reset | !req_write;
      flash_reset_n <= !req_reset;
    end else if ((state != PFC_IDLE) && (state != PFC_DONE) && tmr_expired) begin
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_reset_n <= 1'b1;
    end
  end

  // Width and protect straps follow the user levels.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_byte_n      <= 1'b1;
      protect_accel_pin <= 1'b1;
    end else begin
      flash_byte_n      <= !byte_mode;
      protect_accel_pin <= !protect_outer;
    end
  end

  // ****************************************************************
  // Address and data pins
  // ****************************************************************
  // Address and write data are held for the whole strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_addr    <= '0;
      flash_dq_o    <= '0;
      flash_dq_oe_n <= '1;
    end else if ((state == PFC_IDLE) && req_valid) begin
      flash_addr <= word_addr(req_sector, req_offset);
      flash_dq_o <= req_wdata;
      if (byte_mode) begin
        flash_dq_o[DATA_W-1] <= req_byte_hi;
        flash_dq_oe_n        <= {1'b0, {(DATA_W-1){1'b1}}};
        if (req_write && !req_reset) begin
          flash_dq_oe_n[BYTE_W-1:0] <= '0;
        end
      end else begin
        flash_dq_oe_n <= (req_write && !req_reset) ? '0 : '1;
      end
    end else if ((state == PFC_DONE) && !byte_mode) begin
      flash_dq_oe_n <= '1;
    end else if (state == PFC_DONE) begin
      flash_dq_oe_n <= {1'b0, {(DATA_W-1){1'b1}}};
    end
  end

  // ****************************************************************
  // Read capture
  // ****************************************************************
  // Sample at the end of the OE strobe; byte mode keeps the low lane only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state == PFC_READ) && tmr_expired;
      if ((state == PFC_READ) && tmr_expired) begin
        rsp_rdata <= byte_mode ? {8'h00, flash_dq_i[BYTE_W-1:0]} : flash_dq_i;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_write_pins;
    @(posedge clk) disable iff (!rst_n)
      (state == PFC_WRITE) |-> (!flash_ce_n && flash_oe_n && !flash_we_n && flash_reset_n);
  endproperty
  a_write_pins: assert property (p_write_pins) else $error("write pins wrong");

  property p_read_pins;
    @(posedge clk) disable iff (!rst_n)
      (state == PFC_READ) |-> (!flash_ce_n && !flash_oe_n && flash_we_n && flash_dq_oe_n[BYTE_W-1:0] == 8'hFF);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read pins wrong");

  property p_no_contention;
    @(posedge clk) disable iff (!rst_n)
      !flash_oe_n |-> (flash_dq_oe_n[BYTE_W-1:0] == 8'hFF);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("bus contention");

  sequence s_reset_start;
    (state == PFC_IDLE) && req_valid && req_reset;
  endsequence
  property p_reset_pulse;
    @(posedge clk) disable iff (!rst_n)
      s_reset_start |=> !flash_reset_n [*5];
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse short");

  property p_reset_ends;
    @(posedge clk) disable iff (!rst_n)
      s_reset_start |-> ##[1:8] flash_reset_n;
  endproperty
  a_reset_ends: assert property (p_reset_ends) else $error("reset pulse stuck");

  property p_byte_hi_pin;
    @(posedge clk) disable iff (!rst_n)
      (!flash_byte_n && !flash_ce_n) |-> !flash_dq_oe_n[DATA_W-1];
  endproperty
  a_byte_hi_pin: assert property (p_byte_hi_pin) else $error("byte address pin undriven");

  property p_word_strap;
    @(posedge clk) disable iff (!rst_n)
      byte_mode |=> !flash_byte_n;
  endproperty
  a_word_strap: assert property (p_word_strap) else $error("width strap wrong");

  property p_protect;
    @(posedge clk) disable iff (!rst_n)
      protect_outer |=> !protect_accel_pin;
  endproperty
  a_protect: assert property (p_protect) else $error("protect pin wrong");

  property p_idle_disable;
    @(posedge clk) disable iff (!rst_n)
      ($past(state) == PFC_DONE) |-> (flash_oe_n && flash_we_n);
  endproperty
  a_idle_disable: assert property (p_idle_disable) else $error("strobe left active");

endmodule
`default_nettype wire

//--- verif/pfc_flash_model.sv
// Behavioural flash device that answers the controller's pins.
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model
  import pfc_pkg::*;
(
  // Control pins
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              reset_n,
  input  wire logic              byte_n,
  input  wire logic              protect_accel_pin,
  // Address and data
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq,
  output logic      [DATA_W-1:0] dq_m
);
  // ****************************************************************
  // Array and command latch
  // ****************************************************************
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic [DATA_W-1:0] mlast = 16'h0000;
  logic [DATA_W-1:0] word;
  logic              rd;
  logic              wr;
  logic              armed = 1'b0;
  int                n_wr  = 0;

  // Read needs all four control pins in the read combination.
  assign rd = !ce_n && !oe_n && we_n && reset_n;

  // Write needs all four control pins in the write combination.
  assign wr = !ce_n && oe_n && !we_n && reset_n;

  // Unwritten words show a pattern of both sector and offset, so a wrong sector is seen.
  // The write count is in the list so a program to the address on the pins shows at once.
  always @(addr or n_wr) begin
    word = mem.exists(addr) ? mem[addr] : (addr[15:0] ^ {addr[25:16], 6'h00});
  end

  // Only a write combination that really began may latch; the power-up settle does not.
  always @(posedge wr) armed = 1'b1;

  // The latch sits apart from the array; a program lands unless the outer sector is locked.
  // It closes when the write combination ends, since chip select and write enable
  // may rise together and either ends the cycle.
  always @(negedge wr or negedge reset_n) begin
    if (!reset_n) begin
      cmd_addr = '0;
      cmd_data = '0;
      armed    = 1'b0;
    end else if (armed) begin
      armed    = 1'b0;
      n_wr     = n_wr + 1;
      cmd_addr = addr;
      cmd_data = dq;
      if (protect_accel_pin || addr[25:16] != 10'h3FF) begin
        mem[cmd_addr] = cmd_data;
      end
    end
  end

  // A released bus shows the inverse of the last value, never a stale match.
  always @(negedge rd) mlast = dq_m;

  // Data drive by width; the top pin is the byte address input in byte mode.
  always @* begin
    dq_m = ~mlast;
    if (rd && byte_n) begin
      dq_m = word;
    end else if (rd) begin
      dq_m[7:0] = dq[15] ? word[15:8] : word[7:0];
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_pfc_ctrl.sv
// Self-checking bench for the parallel flash controller.
`timescale 1ns/1ps
`default_nettype none
module tb_pfc_ctrl;
  import pfc_pkg::*;
  typedef struct {
    logic w; logic [9:0] sec; logic [15:0] off; logic bh; logic [15:0] wd; logic bm; logic pr; logic [15:0] ex;
  } pfc_row_t;

  logic                  clk = 1'h0, rst_n = 1'h0, req_valid = 1'h0, req_write = 1'h0;
  logic                  req_reset = 1'h0, req_byte_hi = 1'h0, byte_mode = 1'h0, protect_outer = 1'h0;
  logic [SECT_W-1:0]     req_sector = '0;
  logic [SECT_OFF_W-1:0] req_offset = '0;
  logic [DATA_W-1:0]     req_wdata = '0, rsp_rdata, dq_o, dq_oe_n, dq_m, dq;
  logic                  req_ready, rsp_valid, ce_n, oe_n, we_n, reset_n, byte_n, wp;
  logic [ADDR_W-1:0]     addr;
  int                    n_fail = 0, tests_run = 0, rc, ce_hi;

  // Each wire bit goes to whichever party drives it.
  assign dq = (~dq_oe_n & dq_o) | (dq_oe_n & dq_m);

  // Rows: write, sector, offset, byte bit, data, byte mode, protect, expected read.
  pfc_row_t rows [8] = '{
    '{1'h0, 10'h3FF, 16'hFFFF, 1'h0, 16'h0, 1'h0, 1'h1, 16'h003F},
    '{1'h0, 10'h001, 16'h0000, 1'h0, 16'h0, 1'h0, 1'h1, 16'h0040},
    '{1'h1, 10'h3FF, 16'h0010, 1'h0, 16'h1234, 1'h0, 1'h1, 16'h0},
    '{1'h0, 10'h3FF, 16'h0010, 1'h0, 16'h0, 1'h0, 1'h1, 16'hFFD0},
    '{1'h1, 10'h3FF, 16'h0010, 1'h0, 16'h1234, 1'h0, 1'h0, 16'h0},
    '{1'h0, 10'h3FF, 16'h0010, 1'h0, 16'h0, 1'h0, 1'h0, 16'h1234},
    '{1'h0, 10'h002, 16'h1200, 1'h1, 16'h0, 1'h1, 1'h0, 16'h0012},
    '{1'h0, 10'h002, 16'h1200, 1'h0, 16'h0, 1'h1, 1'h0, 16'h0080}};

  pfc_ctrl i_pfc_ctrl (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write), .req_reset(req_reset),
    .req_sector(req_sector), .req_offset(req_offset), .req_byte_hi(req_byte_hi), .req_wdata(req_wdata),
    .byte_mode(byte_mode), .protect_outer(protect_outer), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_reset_n(reset_n), .flash_byte_n(byte_n), .protect_accel_pin(wp), .flash_addr(addr),
    .flash_dq_i(dq), .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n));

  pfc_flash_model i_pfc_flash_model (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n), .byte_n(byte_n),
    .protect_accel_pin(wp), .addr(addr), .dq(dq), .dq_m(dq_m));

  // One comparison; the count feeds the verdict.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One access; the request is raised once ready, or after 20 cycles without ready, and held for one edge.
  task automatic do_req(input pfc_row_t r, input logic rs);
    logic [15:0] got;
    logic        seen;
    got = 16'hEEEE;
    seen = 1'h0;
    rc = 0;
    ce_hi = 1;
    @(negedge clk);
    byte_mode = r.bm;
    protect_outer = r.pr;
    @(negedge clk);
    for (int k = 0; k < 20 && req_ready !== 1'h1; k++) @(negedge clk);
    req_valid = 1'h1;
    req_write = r.w;
    req_reset = rs;
    req_sector = r.sec;
    req_offset = r.off;
    req_byte_hi = r.bh;
    req_wdata = r.wd;
    @(negedge clk);
    req_valid = 1'h0;
    // Watch the pins for the whole access window.
    for (int k = 0; k < 10; k++) begin
      if (rsp_valid === 1'h1) got = rsp_rdata;
      if (reset_n === 1'h0) rc++;
      if (ce_n !== 1'h1) ce_hi = 0;
      if (ce_n === 1'h0 && !seen) begin
        seen = 1'h1;
        check(16'({oe_n, we_n}), r.w ? 16'h2 : 16'h1);
        check(addr[15:0], r.off);
        check(16'(addr[25:16]), 16'(r.sec));
      end
      @(negedge clk);
    end
    check(16'({byte_n, wp}), 16'({!r.bm, !r.pr}));
    if (!r.w && !rs) check(got, r.ex);
  endtask

  // Free-running 10 MHz clock.
  initial begin
    forever #50 clk = ~clk;
  end

  // Main sequence: reset, table of accesses, then the reset pulse case.
  initial begin
    repeat (12) @(negedge clk);
    check(16'({ce_n, reset_n, req_ready, rsp_valid}), 16'hC);
    check(dq_oe_n, 16'hFFFF);
    rst_n = 1'h1;
    foreach (rows[i]) do_req(rows[i], 1'h0);
    do_req(rows[0], 1'h1);
    check(16'(rc), 16'(RESET_CYC + 1));
    check(16'(ce_hi), 16'h1);
    do_req(rows[5], 1'h0);
    check(dq_oe_n, 16'hFFFF);
    finish_test();
  end

  // Watchdog far beyond the roughly 140 cycles the sequence needs.
  initial begin
    #2000000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
